/* File: dv/rxqh_host_model.sv */
`timescale 1ns/1ps
// host processor on the generic bus, one access per strobe
module rxqh_host_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] rdata_in,
    output logic             cs_n_out,
    output logic             rd_n_out,
    output logic             wr_n_out,
    output logic [7:0]       addr_out,
    output logic [15:0]      wdata_out,
    output logic             rd_ev_out,
    output logic [15:0]      rd_val_out
);
    initial begin
        {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
        addr_out   = 8'h00;
        wdata_out  = 16'h0000;
        rd_ev_out  = 1'b0;
        rd_val_out = 16'h0000;
    end
    // strobe held 8 cycles, past the 3 needed
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_in);
        addr_out  = a;
        wdata_out = d;
        cs_n_out  = 1'b0;
        rd_n_out  = w;
        wr_n_out  = !w;
        repeat (8) @(negedge clk_in);
        if (!w) begin
            rd_val_out = rdata_in;
            rd_ev_out  = ~rd_ev_out;  // toggle tells the bench a word arrived
        end
        {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
        wdata_out = ~d;  // released lines must not keep the old value
        addr_out  = ~a;
        repeat (6) @(negedge clk_in);
    endtask
endmodule

/* File: dv/rxqh_monitor.sv */
`timescale 1ns/1ps
// port-level watcher of the receive queue host side
module rxqh_monitor (
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    input wire logic        host_cs_n_in,
    input wire logic        host_rd_n_in,
    input wire logic        host_wr_n_in,
    input wire logic [15:0] host_data_out,
    input wire logic        host_data_oe_out,
    input wire logic        host_irq_out,
    input wire logic        rx_flow_ctrl_en_out,
    input wire logic [3:0]  rx_csum_en_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic wr_seen_ff;  // a write has reached the pins since reset
    // no interrupt before the first write
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) wr_seen_ff <= 1'b0;
        else if (!host_wr_n_in && !host_cs_n_in) wr_seen_ff <= 1'b1;
    end
    sequence rd_idle; host_rd_n_in[*6]; endsequence
    sequence wr_busy; (!host_wr_n_in)[*6]; endsequence
    a_reset_outs_quiet: assert property ($rose(rst_n_in) |-> !host_irq_out &&
        !host_data_oe_out && !rx_flow_ctrl_en_out && rx_csum_en_out == 4'h0)
        else $error("outputs not quiet after reset");
    a_oe_needs_read: assert property ($rose(host_data_oe_out) |->
        $past(!host_rd_n_in && !host_cs_n_in, 2)) else $error("oe without read");
    a_oe_read_release: assert property (rd_idle |-> !host_data_oe_out)
        else $error("oe held after read");
    a_oe_not_write: assert property (wr_busy |-> !host_data_oe_out)
        else $error("oe during write");
    a_data_holds: assert property ((!host_data_oe_out)[*2] |-> $stable(host_data_out))
        else $error("read data moved while idle");
    a_flow_by_write: assert property ($changed(rx_flow_ctrl_en_out) |->
        $past(!host_wr_n_in, 3)) else $error("flow enable moved without write");
    a_csum_by_write: assert property ($changed(rx_csum_en_out) |->
        $past(!host_wr_n_in, 3)) else $error("checksum enables moved without write");
    a_irq_needs_enable: assert property (host_irq_out |-> wr_seen_ff)
        else $error("interrupt before any enable");
endmodule
bind rxqh_top rxqh_monitor u_mon (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .host_cs_n_in(host_cs_n_in), .host_rd_n_in(host_rd_n_in), .host_wr_n_in(host_wr_n_in),
    .host_data_out(host_data_out), .host_data_oe_out(host_data_oe_out),
    .host_irq_out(host_irq_out), .rx_flow_ctrl_en_out(rx_flow_ctrl_en_out),
    .rx_csum_en_out(rx_csum_en_out));

/* File: dv/rxqh_tb_top.sv */
`timescale 1ns/1ps
module rxqh_tb_top;
    localparam int NB = 66;  // frame bytes, CRC included
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs_n, rd_n, wr_n, oe, irq, fc, rdev;
    logic        be = 1'b0, rxv = 1'b0, rxl = 1'b0;
    logic [7:0]  addr, rxb = 8'h00;
    logic [15:0] wdata, din, dout, rdv, st, rxs = 16'h0000;
    logic [3:0]  c4, csum;
    logic [7:0]  fb[NB];
    logic [24:0] notes[$];  // {checked, address, expected}
    int          n_mismatch = 0, checks_done = 0, cyc = 0;
    always #2.5 clk = ~clk;
    assign din = oe ? dout : wdata;  // shared data pins
    rxqh_top dut (.ref_clk_in(clk), .rst_n_in(rst_n), .host_cs_n_in(cs_n),
        .host_rd_n_in(rd_n), .host_wr_n_in(wr_n), .host_addr_in(addr), .host_data_in(din),
        .host_data_out(dout), .host_data_oe_out(oe), .host_irq_out(irq),
        .big_endian_in(be), .rx_valid_in(rxv), .rx_byte_in(rxb), .rx_last_in(rxl),
        .rx_status_in(rxs), .rx_flow_ctrl_en_out(fc), .rx_csum_en_out(csum));
    rxqh_host_model host (.clk_in(clk), .rdata_in(dout), .cs_n_out(cs_n), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .addr_out(addr), .wdata_out(wdata), .rd_ev_out(rdev),
        .rd_val_out(rdv));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.acc(1'b1, a, d);
    endtask
    // note first, compared on arrival
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input bit c = 1'b1);
        notes.push_back({c, a, e});
        host.acc(1'b0, a, 16'h0000);
    endtask
    // one receive frame, then a gap for the writer
    task automatic send();
        for (int i = 0; i < NB; i++) begin
            @(negedge clk);
            {rxv, rxb, rxl, rxs} = {1'b1, fb[i], i == NB - 1, st};
        end
        @(negedge clk);
        {rxv, rxl} = 2'h0;
        repeat (6) @(negedge clk);
    endtask
    always @(rdev) begin
        logic [24:0] n;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            if (n[24]) check($sformatf("reg %h", n[23:16]), rdv, n[15:0]);
        end
    end
    // hang guard, the run needs about 1100 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        void'($urandom(81));
        foreach (fb[i]) fb[i] = 8'($urandom);
        st = 16'($urandom);
        c4 = 4'($urandom);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h9C, 16'h0000);
        wr(8'h74, 16'h0401);
        check("flow", 16'(fc), 16'h0001);
        rd(8'h74, 16'h0401);
        wr(8'h76, {12'h000, c4});
        check("csum", 16'(csum), 16'(c4));
        rd(8'h00, 16'h0000);
        wr(8'h8E, 16'h0040);
        wr(8'h8C, 16'hFFFF);
        wr(8'h82, 16'h0200);
        send();
        rd(8'h9C, 16'h0000, 1'b0);
        rd(8'h7C, st);
        rd(8'h7E, 16'(NB));
        be = 1'b1;
        wr(8'h86, 16'h4000);
        wr(8'h82, 16'h0218);
        rd(8'hD0, 16'h0000);
        rd(8'hD0, {st[7:0], st[15:8]});
        rd(8'hD0, {8'(NB), 8'h00});
        rd(8'hD0, 16'h0000);
        for (int i = 0; i < NB / 2; i++) rd(8'hD0, {fb[2*i+1], fb[2*i]});
        wr(8'h82, 16'h0010);
        wr(8'h90, 16'h2000);
        wr(8'h9C, 16'h0000);
        wr(8'h82, 16'h0060);
        check("irq empty", 16'(irq), 16'h0000);
        send();
        check("irq", 16'(irq), 16'h0001);
        rd(8'h82, 16'h0C60);
        rd(8'h92, 16'h2000);
        rd(8'h9C, 16'h0100);
        wr(8'h90, 16'h0000);
        check("irq masked", 16'(irq), 16'h0000);
        wr(8'h82, 16'h0000);
        wr(8'h92, 16'hFFFF);
        rd(8'h92, 16'h0000);
        summarize();
    end
endmodule

/* File: src/rxqh_defs.svh */
// Overview of operation
// R1 - status word, then byte count, then frame data
// R2 - data keeps CRC, at most 2000 bytes
// R3 - big-endian mode swaps header word bytes
// R4 - primary control bit 10 enables flow control
// R5 - primary control bit 0 enables frame acceptance
// R6 - separate checksum check enables for ICMP/UDP/TCP/IP
// R7 - read-only head frame status register
// R8 - read-only head frame byte count, bits 11:0
// R9 - queue control bit 3 starts data-port session
// R10 - queue control bit 4 releases read frame automatically
// R11 - frame count over threshold raises interrupt, status
// R12 - queued bytes over threshold raise interrupt, status
// R13 - head frame age over threshold raises interrupt
// R14 - queue control bit 9 inserts two-byte offset
// R15 - pointer bit 14 auto-advances on data access
// R16 - enable bit 13 gates the receive interrupt
// R17 - interrupt status bits clear on written ones
// R18 - frame counter upper byte latches queued frames
// R19 - first data-port read of session is dummy
// R20 - clearing receive interrupt refreshes frame count
// R21 - count read loads header, header reads advance
// R22 - interrupt output follows pending and enabled bits
`ifndef RXQH_DEFS_SVH
`define RXQH_DEFS_SVH

// register offsets on the host bus
`define RXQH_OFF_CTL1      8'h74
`define RXQH_OFF_CTL2      8'h76
`define RXQH_OFF_HSTAT     8'h7C
`define RXQH_OFF_HBCNT     8'h7E
`define RXQH_OFF_QCTL      8'h82
`define RXQH_OFF_DPTR      8'h86
`define RXQH_OFF_AGETHR    8'h8C
`define RXQH_OFF_BYTETHR   8'h8E
`define RXQH_OFF_IER       8'h90
`define RXQH_OFF_ISR       8'h92
`define RXQH_OFF_FCNT      8'h9C
`define RXQH_OFF_DATA      8'hD0

// field positions
`define RXQH_CTL1_EN       0
`define RXQH_CTL1_FC       10
`define RXQH_QCTL_REL      0
`define RXQH_QCTL_SESS     3
`define RXQH_QCTL_AUTO     4
`define RXQH_QCTL_FTHR     5
`define RXQH_QCTL_BTHR     6
`define RXQH_QCTL_ATHR     7
`define RXQH_QCTL_OFS2     9
`define RXQH_DPTR_AINC     14
`define RXQH_IRQ_RX        13

// sizes and timing
`define RXQH_MAX_BYTES     12'h7D0
`define RXQH_TICK_NS       1000
`define RXQH_CLK_MHZ       200
`define RXQH_TICK_CYC      (`RXQH_TICK_NS * `RXQH_CLK_MHZ / 1000)
`define RXQH_BUS_RST       28'hE000000

`endif

/* File: src/rxqh_mem_if.sv */
`timescale 1ns/1ps
interface rxqh_mem_if #(parameter int AW = 10);
    logic          we;     // write strobe
    logic [AW-1:0] waddr;  // write word index
    logic [15:0]   wdata;  // write word
    logic [AW-1:0] raddr;  // read word index
    logic [15:0]   rdata;  // read word, combinational

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: src/rxqh_pkg.sv */
package rxqh_pkg;
    // frame writer states, gray along idle-recv-stat-cnt
    typedef enum logic [1:0] {
        RXQH_IDLE = 2'h0,
        RXQH_RECV = 2'h1,
        RXQH_STAT = 2'h3,
        RXQH_CNT  = 2'h2
    } rxqh_wstate_t;

    // one queued frame descriptor
    typedef struct packed {
        logic [15:0] status;
        logic [11:0] bcnt;
        logic [15:0] base;
    } rxqh_desc_t;
endpackage

/* File: src/rxqh_store.sv */
`timescale 1ns/1ps
// word store of the receive queue, flip-flops with one write and one read port
module rxqh_store #(
    parameter int AW = 10
) (
    input  wire logic ref_clk_in,
    rxqh_mem_if.store mem
);
    logic [15:0] mem_ff [2**AW];  // queue storage, no reset: content is data only

    // write port
    always_ff @(posedge ref_clk_in) begin
        if (mem.we) begin
            mem_ff[mem.waddr] <= mem.wdata;
        end
    end

    // read port is combinational so the bus slave samples it in one cycle
    assign mem.rdata = mem_ff[mem.raddr];
endmodule

/* File: src/rxqh_top.sv */
`timescale 1ns/1ps
`include "rxqh_defs.svh"
module rxqh_top #(
    parameter int AW     = 10,  // log2 of queue words
    parameter int FRAMES = 8    // descriptor slots, power of two
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        host_cs_n_in,
    input  wire logic        host_rd_n_in,
    input  wire logic        host_wr_n_in,
    input  wire logic [7:0]  host_addr_in,
    input  wire logic [15:0] host_data_in,
    output logic      [15:0] host_data_out,
    output logic             host_data_oe_out,
    output logic             host_irq_out,
    input  wire logic        big_endian_in,
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_byte_in,
    input  wire logic        rx_last_in,
    input  wire logic [15:0] rx_status_in,
    output logic             rx_flow_ctrl_en_out,
    output logic      [3:0]  rx_csum_en_out
);
    localparam int FW = $clog2(FRAMES);

    // refuse shapes the pointers cannot serve
    generate
        if (AW < 10 || AW > 15 || FRAMES < 2 || FRAMES > 128 || (1 << FW) != FRAMES) begin : g_chk
            $error("rxqh_top: unsupported AW or FRAMES");
        end
    endgenerate

    rxqh_mem_if #(.AW(AW)) mem ();

    rxqh_store #(.AW(AW)) u_store (
        .ref_clk_in (ref_clk_in),
        .mem        (mem)
    );

    // pin synchroniser: stage one feeds stage two only
    logic [27:0] bus_s1_ff;   // first stage
    logic [27:0] bus_s2_ff;   // second stage, read by logic
    logic [27:0] bus_p_ff;    // previous second stage for strobe edges
    logic [1:0]  be_ff;       // endian strap synchroniser
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_s1_ff <= `RXQH_BUS_RST;
            bus_s2_ff <= `RXQH_BUS_RST;
            bus_p_ff  <= `RXQH_BUS_RST;
            be_ff     <= 2'h0;
        end else begin
            bus_s1_ff <= {host_cs_n_in, host_rd_n_in, host_wr_n_in, 1'b0,
                          host_addr_in, host_data_in};
            bus_s2_ff <= bus_s1_ff;
            bus_p_ff  <= bus_s2_ff;
            be_ff     <= {be_ff[0], big_endian_in};
        end
    end

    // decoded bus view
    wire        s_cs   = !bus_s2_ff[27];
    wire        rd_go  = s_cs && !bus_s2_ff[26] && bus_p_ff[26];
    wire        wr_go  = s_cs && !bus_s2_ff[25] && bus_p_ff[25];
    wire        rd_act = s_cs && !bus_s2_ff[26];
    wire [7:0]  s_addr = bus_s2_ff[23:16];
    wire [15:0] s_data = bus_s2_ff[15:0];
    wire        big_e  = be_ff[1];

    // swap bytes of a header word when the host is big-endian
    function automatic logic [15:0] hdr_swap(input logic [15:0] w, input logic sw);
        hdr_swap = sw ? {w[7:0], w[15:8]} : w;
    endfunction

    // software registers
    logic [15:0] ctl1_ff;      // primary receive control
    logic [15:0] ctl2_ff;      // secondary receive control
    logic [9:0]  qctl_ff;      // writable queue control bits
    logic [15:0] dptr_ff;      // data pointer, byte offset in 10:0
    logic [15:0] age_thr_ff;   // frame age threshold in ticks
    logic [15:0] byte_thr_ff;  // queued byte threshold
    logic [15:0] ier_ff;       // interrupt enables
    logic        isr_rx_ff;    // sticky receive interrupt
    logic [7:0]  fthr_ff;      // frame count threshold
    logic [7:0]  fcnt_lat_ff;  // frames held when interrupt raised or cleared
    logic [15:0] hstat_ff;     // head status shadow
    logic [11:0] hbc_ff;       // head byte count shadow
    logic        seen_s_ff;    // status shadow read since load
    logic        seen_b_ff;    // count shadow read since load
    logic        dummy_ff;     // next data read is the dummy one
    logic [15:0] rdata_ff;     // bus read data
    logic        oe_ff;        // bus drive enable
    logic        irq_ff;       // interrupt output

    // descriptor queue
    rxqh_pkg::rxqh_desc_t desc_ff [FRAMES];
    logic [FW-1:0] th_ff;      // head slot
    logic [FW-1:0] tw_ff;      // tail slot
    logic [FW-1:0] pk_ff;      // slot loaded next into the shadows
    logic [FW:0]   fc_ff;      // frames queued
    logic [15:0]   qbytes_ff;  // bytes queued
    logic [15:0]   age_ff;     // age of head frame in ticks
    logic [7:0]    tick_ff;    // microsecond divider
    logic          tick_ff_p;  // one-cycle tick enable

    // frame writer
    rxqh_pkg::rxqh_wstate_t st_ff;
    logic [AW-1:0] wp_ff;      // next free word for a new frame
    logic [AW-1:0] base_ff;    // base of frame being written
    logic [AW-1:0] dp_ff;      // next data word
    logic [11:0]   bc_ff;      // bytes received so far
    logic [7:0]    lo_ff;      // first byte of pending pair
    logic          drop_ff;    // current frame is discarded
    logic [15:0]   stat_ff;    // status captured at last byte

    rxqh_pkg::rxqh_desc_t head_d;
    rxqh_pkg::rxqh_desc_t peek_d;
    assign head_d = desc_ff[th_ff];
    assign peek_d = desc_ff[pk_ff];

    // host access decode
    wire wr_ctl1  = wr_go && s_addr == `RXQH_OFF_CTL1;
    wire wr_ctl2  = wr_go && s_addr == `RXQH_OFF_CTL2;
    wire wr_qctl  = wr_go && s_addr == `RXQH_OFF_QCTL;
    wire wr_dptr  = wr_go && s_addr == `RXQH_OFF_DPTR;
    wire wr_age   = wr_go && s_addr == `RXQH_OFF_AGETHR;
    wire wr_byte  = wr_go && s_addr == `RXQH_OFF_BYTETHR;
    wire wr_ier   = wr_go && s_addr == `RXQH_OFF_IER;
    wire wr_isr   = wr_go && s_addr == `RXQH_OFF_ISR;
    wire wr_fcnt  = wr_go && s_addr == `RXQH_OFF_FCNT;
    wire rd_fcnt  = rd_go && s_addr == `RXQH_OFF_FCNT;
    wire rd_hstat = rd_go && s_addr == `RXQH_OFF_HSTAT;
    wire rd_hbc   = rd_go && s_addr == `RXQH_OFF_HBCNT;
    wire rd_data  = rd_go && s_addr == `RXQH_OFF_DATA && qctl_ff[`RXQH_QCTL_SESS]; // [R9]

    // session start arms the dummy word; closing it with auto-dequeue releases
    wire sess_on  = wr_qctl && s_data[`RXQH_QCTL_SESS] && !qctl_ff[`RXQH_QCTL_SESS];
    wire sess_off = wr_qctl && !s_data[`RXQH_QCTL_SESS] && qctl_ff[`RXQH_QCTL_SESS];
    wire auto_rel = sess_off && qctl_ff[`RXQH_QCTL_AUTO];                 // [R10]
    wire man_rel  = wr_qctl && s_data[`RXQH_QCTL_REL];
    wire pop      = (auto_rel || man_rel) && fc_ff != '0;

    // threshold status, live
    wire fst = qctl_ff[`RXQH_QCTL_FTHR] && {{(7-FW){1'b0}}, fc_ff} > fthr_ff; // [R11]
    wire bst = qctl_ff[`RXQH_QCTL_BTHR] && qbytes_ff > byte_thr_ff;         // [R12]
    wire ast = qctl_ff[`RXQH_QCTL_ATHR] && fc_ff != '0 && age_ff > age_thr_ff; // [R13]
    wire rx_evt = fst || bst || ast;

    // set wins over the written-one clear
    wire isr_clr      = wr_isr && s_data[`RXQH_IRQ_RX];                    // [R17]
    wire nxt_isr_rx   = rx_evt || (isr_rx_ff && !isr_clr);
    wire lat_fcnt     = (rx_evt && !isr_rx_ff) || isr_clr;                 // [R18] [R20]

    // data port word address and read value
    wire [9:0]  ptr_w  = dptr_ff[10:1];
    wire        hdr_w  = ptr_w < 10'h2;
    assign mem.raddr   = AW'(head_d.base) + AW'(ptr_w);
    wire [15:0] dport  = dummy_ff ? 16'h0000 : hdr_swap(mem.rdata, big_e && hdr_w); // [R3] [R19]
    wire [15:0] qctl_rd = {3'h0, ast, bst, fst, qctl_ff[9:1], 1'b0};

    // register read mux, unmapped offsets read zero
    wire [15:0] rd_mux =
        s_addr == `RXQH_OFF_CTL1    ? ctl1_ff :
        s_addr == `RXQH_OFF_CTL2    ? ctl2_ff :
        s_addr == `RXQH_OFF_HSTAT   ? hstat_ff :                               // [R7]
        s_addr == `RXQH_OFF_HBCNT   ? {4'h0, hbc_ff} :                         // [R8]
        s_addr == `RXQH_OFF_QCTL    ? qctl_rd :
        s_addr == `RXQH_OFF_DPTR    ? dptr_ff :
        s_addr == `RXQH_OFF_AGETHR  ? age_thr_ff :
        s_addr == `RXQH_OFF_BYTETHR ? byte_thr_ff :
        s_addr == `RXQH_OFF_IER     ? ier_ff :
        s_addr == `RXQH_OFF_ISR     ? {2'h0, isr_rx_ff, 13'h0000} :
        s_addr == `RXQH_OFF_FCNT    ? {fcnt_lat_ff, fthr_ff} :
        s_addr == `RXQH_OFF_DATA    ? dport : 16'h0000;

    // writer datapath
    wire        wr_idle  = st_ff == rxqh_pkg::RXQH_IDLE;
    wire        take     = rx_valid_in && (wr_idle || st_ff == rxqh_pkg::RXQH_RECV);
    wire        accept   = ctl1_ff[`RXQH_CTL1_EN] && fc_ff < FRAMES;          // [R5]
    wire [AW-1:0] st_dp  = wp_ff + (ctl1_ff[`RXQH_CTL1_EN] && qctl_ff[`RXQH_QCTL_OFS2]
                           ? AW'(3) : AW'(2));                               // [R1] [R14]
    wire [AW-1:0] cur_dp = wr_idle ? st_dp : dp_ff;
    wire [11:0] cur_bc   = wr_idle ? 12'h000 : bc_ff;
    wire        cur_drop = wr_idle ? !accept : drop_ff;
    wire [AW-1:0] used   = cur_dp - AW'(head_d.base);
    wire        full     = fc_ff != '0 && used >= {{(AW-1){1'b1}}, 1'b0};
    wire        too_long = cur_bc >= `RXQH_MAX_BYTES;                        // [R2]
    wire        nxt_drop = cur_drop || full || too_long;
    wire        pair     = cur_bc[0];
    wire        wr_byte_w = take && !nxt_drop && (pair || rx_last_in);
    wire [AW-1:0] fin_wp = dp_ff[0] ? dp_ff + AW'(1) : dp_ff;
    wire        push     = st_ff == rxqh_pkg::RXQH_CNT;
    wire        pad_w    = take && wr_idle && !nxt_drop && !wr_byte_w && qctl_ff[`RXQH_QCTL_OFS2];

    // storage write port: data pairs, then status, then count
    assign mem.we    = wr_byte_w || pad_w || st_ff == rxqh_pkg::RXQH_STAT || push;
    assign mem.waddr = st_ff == rxqh_pkg::RXQH_STAT ? base_ff :
                       push ? base_ff + AW'(1) : cur_dp - AW'(pad_w);          // [R1]
    assign mem.wdata = st_ff == rxqh_pkg::RXQH_STAT ? stat_ff :
                       push ? {4'h0, bc_ff} :
                       pad_w ? 16'h0000 : pair ? {rx_byte_in, lo_ff} : {8'h00, rx_byte_in};

    // writer state machine, frame bytes include the CRC
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff   <= rxqh_pkg::RXQH_IDLE;
            wp_ff   <= '0;
            base_ff <= '0;
            dp_ff   <= '0;
            bc_ff   <= 12'h000;
            lo_ff   <= 8'h00;
            drop_ff <= 1'b0;
            stat_ff <= 16'h0000;
        end else begin
            case (st_ff)
                rxqh_pkg::RXQH_IDLE, rxqh_pkg::RXQH_RECV: begin
                    if (take) begin
                        if (wr_idle) begin
                            base_ff <= wp_ff;
                        end
                        dp_ff   <= wr_byte_w ? cur_dp + AW'(1) : cur_dp;
                        bc_ff   <= cur_bc + 12'h001;
                        lo_ff   <= rx_byte_in;
                        drop_ff <= nxt_drop;
                        stat_ff <= rx_status_in;
                        if (rx_last_in) begin
                            st_ff <= nxt_drop ? rxqh_pkg::RXQH_IDLE : rxqh_pkg::RXQH_STAT;
                        end else begin
                            st_ff <= rxqh_pkg::RXQH_RECV;
                        end
                    end
                end
                rxqh_pkg::RXQH_STAT: begin
                    st_ff <= rxqh_pkg::RXQH_CNT;
                end
                rxqh_pkg::RXQH_CNT: begin
                    // next frame starts on an even word so reads end on a dword
                    wp_ff <= fin_wp;
                    st_ff <= rxqh_pkg::RXQH_IDLE;
                end
                default: begin
                    st_ff <= rxqh_pkg::RXQH_IDLE;
                end
            endcase
        end
    end

    // descriptor queue, counts and head age
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < FRAMES; i++) begin
                desc_ff[i] <= '0;
            end
            th_ff     <= '0;
            tw_ff     <= '0;
            fc_ff     <= '0;
            qbytes_ff <= 16'h0000;
            age_ff    <= 16'h0000;
            tick_ff   <= 8'h00;
            tick_ff_p <= 1'b0;
        end else begin
            tick_ff   <= tick_ff == 8'(`RXQH_TICK_CYC - 1) ? 8'h00 : tick_ff + 8'h01;
            tick_ff_p <= tick_ff == 8'(`RXQH_TICK_CYC - 1);
            if (push) begin
                desc_ff[tw_ff] <= '{status: stat_ff, bcnt: bc_ff, base: 16'(base_ff)};
                tw_ff <= tw_ff + FW'(1);
            end
            if (pop) begin
                th_ff <= th_ff + FW'(1);
            end
            fc_ff <= fc_ff + (FW+1)'(push) - (FW+1)'(pop);
            qbytes_ff <= qbytes_ff + (push ? {4'h0, bc_ff} : 16'h0000)
                                   - (pop ? {4'h0, head_d.bcnt} : 16'h0000);
            if (pop || fc_ff == '0) begin
                age_ff <= 16'h0000;                                           // [R13]
            end else if (tick_ff_p && age_ff != 16'hFFFF) begin
                age_ff <= age_ff + 16'h0001;
            end
        end
    end

    // software registers and the dummy-read flag
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctl1_ff     <= 16'h0000;
            ctl2_ff     <= 16'h0000;
            qctl_ff     <= 10'h000;
            dptr_ff     <= 16'h0000;
            age_thr_ff  <= 16'h0000;
            byte_thr_ff <= 16'h0000;
            ier_ff      <= 16'h0000;
            isr_rx_ff   <= 1'b0;
            fthr_ff     <= 8'h00;
            fcnt_lat_ff <= 8'h00;
            dummy_ff    <= 1'b0;
        end else begin
            if (wr_ctl1) ctl1_ff <= s_data;
            if (wr_ctl2) ctl2_ff <= s_data;
            if (wr_qctl) qctl_ff <= {s_data[9:1], 1'b0};  // release bit self-clears
            if (wr_age)  age_thr_ff <= s_data;
            if (wr_byte) byte_thr_ff <= s_data;
            if (wr_ier)  ier_ff <= s_data;
            if (wr_fcnt) fthr_ff <= s_data[7:0];
            isr_rx_ff <= nxt_isr_rx;                                          // [R17]
            if (lat_fcnt) begin
                fcnt_lat_ff <= 8'(fc_ff);                                     // [R18] [R20]
            end
            // pointer write wins; auto-advance skips the dummy read
            if (wr_dptr) begin
                dptr_ff <= s_data;
            end else if (rd_data && !dummy_ff && dptr_ff[`RXQH_DPTR_AINC]) begin
                dptr_ff <= {dptr_ff[15:11], dptr_ff[10:0] + 11'h002};          // [R15]
            end else if (pop) begin
                dptr_ff <= {dptr_ff[15:11], 11'h000};
            end
            if (sess_on) begin
                dummy_ff <= 1'b1;                                             // [R19]
            end else if (rd_data) begin
                dummy_ff <= 1'b0;
            end
        end
    end

    // header shadows: count read loads head, reading both loads the next
    wire both_seen = (rd_hstat || seen_s_ff) && (rd_hbc || seen_b_ff);
    wire [FW:0] pk_ofs = {1'b0, pk_ff - th_ff};
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hstat_ff  <= 16'h0000;
            hbc_ff    <= 12'h000;
            seen_s_ff <= 1'b0;
            seen_b_ff <= 1'b0;
            pk_ff     <= '0;
        end else if (rd_fcnt) begin
            hstat_ff  <= fc_ff != '0 ? head_d.status : 16'h0000;             // [R21]
            hbc_ff    <= fc_ff != '0 ? head_d.bcnt : 12'h000;
            pk_ff     <= th_ff + FW'(1);
            seen_s_ff <= 1'b0;
            seen_b_ff <= 1'b0;
        end else if (both_seen) begin
            hstat_ff  <= pk_ofs < fc_ff ? peek_d.status : 16'h0000;          // [R21]
            hbc_ff    <= pk_ofs < fc_ff ? peek_d.bcnt : 12'h000;
            pk_ff     <= pk_ff + FW'(1);
            seen_s_ff <= 1'b0;
            seen_b_ff <= 1'b0;
        end else begin
            seen_s_ff <= seen_s_ff || rd_hstat;
            seen_b_ff <= seen_b_ff || rd_hbc;
            if (pop && pk_ff == th_ff) begin
                pk_ff <= th_ff + FW'(1);
            end
        end
    end

    // output flops: bus data, drive enable, interrupt, control bits
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff            <= 16'h0000;
            oe_ff               <= 1'b0;
            irq_ff              <= 1'b0;
            rx_flow_ctrl_en_out <= 1'b0;
            rx_csum_en_out      <= 4'h0;
        end else begin
            if (rd_go) rdata_ff <= rd_mux;
            oe_ff  <= rd_act;
            irq_ff <= nxt_isr_rx && ier_ff[`RXQH_IRQ_RX];                    // [R16] [R22]
            rx_flow_ctrl_en_out <= ctl1_ff[`RXQH_CTL1_FC];                   // [R4]
            rx_csum_en_out      <= ctl2_ff[3:0];                             // [R6]
        end
    end

    assign host_data_out    = rdata_ff;
    assign host_data_oe_out = oe_ff;
    assign host_irq_out     = irq_ff;
endmodule
